// *** rtl/dbu_pkg.sv ***
// dbu_pkg: constants for the debug breakpoint unit
// assumes a 32-bit avalon-mm register port, word addressed by byte offset
package dbu_pkg;
  // register byte offsets
  localparam logic [4:0] DBU_OFF_ADDR0   = 5'h00;
  localparam logic [4:0] DBU_OFF_ADDR1   = 5'h04;
  localparam logic [4:0] DBU_OFF_ADDR2   = 5'h08;
  localparam logic [4:0] DBU_OFF_ADDR3   = 5'h0C;
  localparam logic [4:0] DBU_OFF_ALIAS4  = 5'h10;
  localparam logic [4:0] DBU_OFF_ALIAS5  = 5'h14;
  localparam logic [4:0] DBU_OFF_STATUS  = 5'h18;
  localparam logic [4:0] DBU_OFF_CONTROL = 5'h1C;
  // control field positions
  localparam int DBU_CTL_LEXACT = 8;
  localparam int DBU_CTL_GEXACT = 9;
  localparam int DBU_CTL_GUARD  = 13;
  localparam int DBU_CTL_TYPE0  = 16;
  // status field positions
  localparam int DBU_ST_ACCESS  = 13;
  localparam int DBU_ST_STEP    = 14;
  localparam int DBU_ST_TASK    = 15;
  // other positions
  localparam int DBU_FLAGS_TRAP = 8;
  localparam int DBU_CR4_EXT    = 3;
  // reset values
  localparam logic [31:0] DBU_CTL_RESET  = 32'h0000_0400;
  localparam logic [31:0] DBU_ST_RESET   = 32'hFFFF_0FF0;
  localparam logic [31:0] DBU_ST_FIXED1  = 32'hFFFF_0FF0;
  localparam logic [31:0] DBU_CTL_FIXED1 = 32'h0000_0400;
  localparam logic [31:0] DBU_CTL_WMASK  = 32'hFFFF_23FF;
  // exception vectors and opcode
  localparam logic [7:0]  DBU_VEC_DEBUG  = 8'h01;
  localparam logic [7:0]  DBU_VEC_BKPT   = 8'h03;
  localparam logic [7:0]  DBU_OP_BKPT    = 8'hCC;
  // breakpoint type encodings
  localparam logic [1:0]  DBU_TY_EXEC    = 2'h0;
  localparam logic [1:0]  DBU_TY_WRITE   = 2'h1;
  localparam logic [1:0]  DBU_TY_IO      = 2'h2;
  localparam logic [1:0]  DBU_TY_DATA    = 2'h3;
  // cycle kinds reported by the pipeline
  typedef enum logic [1:0] {
    DBU_CYC_FETCH, DBU_CYC_READ, DBU_CYC_WRITE, DBU_CYC_IO
  } dbu_cyc_t;
endpackage

// *** rtl/dbu_unit.sv ***
// dbu_unit: breakpoint registers, matching and debug exception raising
// assumes pipeline inputs are on clock_in; one exception report per pulse
//
// What this block does
// - four 32-bit breakpoint linear address registers
// - compare addresses against cycles, qualified by type
// - extensions off: regs five/four alias seven/six
// - extensions on: regs five/four raise undefined opcode
// - hit sets flag, and identical conditions too
// - disabled breakpoints never raise an exception
// - guarded debug register access flags, faults first
// - trap flag raises step trap, sets flag
// - task trap bit sets flag, raises exception
// - task switch clears local enables
// - global enables survive task switch, arm alone
// - exact bits stored, no effect
// - guard enable cleared on any debug exception
// - type and size field encodings
// - data, io, step, task are vector 01h traps
// - exec breakpoints and access detect are faults
// - opcode CCh raises vector 03h trap
//
// register map: four address words, two alias words, status, control
// the alias words read zero and drop writes once extensions are on
// hit flags are only recorded in a cycle that raises a debug exception,
// so an idle match on a disabled breakpoint leaves the status untouched
// size 10b decodes as one byte; software is expected never to use it
// exception reports are one-cycle pulses; the pipeline must take them
// in the cycle they stand, nothing here queues a second report
// a guard fault hides an undefined-opcode report in the same cycle,
// since the debugger must see the access before it happens
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dbu_unit
  import dbu_pkg::*;
#(
  parameter int NUM_BP = 4
)(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // avalon-mm register port
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // processor state
  input  wire logic [31:0] control_reg_four_in,
  input  wire logic [31:0] flags_word_in,
  // bus cycle observation
  input  wire logic        cyc_valid_in,
  input  wire logic [1:0]  cyc_kind_in,
  input  wire logic [31:0] cyc_addr_in,
  input  wire logic [2:0]  cyc_size_in,
  // instruction events
  input  wire logic        instr_done_in,
  input  wire logic [7:0]  instr_opcode_in,
  input  wire logic        dreg_decode_in,
  input  wire logic [2:0]  dreg_num_in,
  input  wire logic        task_switch_in,
  input  wire logic        task_trap_bit_in,
  // exception reports
  output logic             fault_out,
  output logic             trap_out,
  output logic [7:0]       vector_out,
  output logic             undef_op_out
);

  logic [31:0] addr_r [NUM_BP];
  logic [31:0] ctl_r;
  logic [31:0] st_r;
  logic [31:0] rdata_r;
  logic        wait_r;
  logic        fault_r;
  logic        trap_r;
  logic [7:0]  vec_r;
  logic        undef_r;
  logic [NUM_BP-1:0] match_w;
  logic [NUM_BP-1:0] armed_w;
  logic        ext_on;
  logic        bp_fault;
  logic        bp_trap;
  logic        step_ev;
  logic        task_ev;
  logic        guard_ev;
  logic        sw_ev;
  logic        any_dbg;
  logic        acc_w;
  logic        wr_w;
  logic [2:0]  sel_reg;

  // byte enable merge used by every register write
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // cycle kind test for one breakpoint type; data covers both directions
  // io cycles only ever match the io type, never a data breakpoint
  function automatic logic kind_hit(input logic [1:0] ty,
                                    input logic [1:0] kind);
    logic hit;
    hit = 1'b0;
    if (ty == DBU_TY_EXEC)
      hit = (kind == DBU_CYC_FETCH);
    else if (ty == DBU_TY_WRITE)
      hit = (kind == DBU_CYC_WRITE);
    else if (ty == DBU_TY_IO)
      hit = (kind == DBU_CYC_IO);
    else
      hit = (kind == DBU_CYC_READ) || (kind == DBU_CYC_WRITE);
    return hit;
  endfunction

  // breakpoint range test: size 00 one byte, 01 two, 11 four
  // the breakpoint address is aligned down to its own size, so a
  // misaligned address still covers the aligned word around it
  function automatic logic in_range(input logic [31:0] bp,
                                    input logic [1:0]  len,
                                    input logic [31:0] a,
                                    input logic [2:0]  sz);
    logic [31:0] mask;
    logic [31:0] last;
    mask = (len == 2'h1) ? 32'hFFFF_FFFE :
           (len == 2'h3) ? 32'hFFFF_FFFC : 32'hFFFF_FFFF;
    last = a + {29'h0, sz} - 32'h1;
    return ((a & mask) <= (bp & mask)) && ((bp & mask) <= last);
  endfunction

  assign ext_on = control_reg_four_in[DBU_CR4_EXT];
  // reads load data in the wait cycle so it stands when wait drops;
  // writes land only at the edge the master sees wait low, so a
  // request that never completes never half-commits a register
  assign acc_w  = (avs_read_in | avs_write_in) & wait_r;
  assign wr_w   = avs_write_in & !wait_r;

  // aliasing of five/four onto seven/six when extensions are off
  // with extensions on the words keep their own index and fall
  // through to the unmapped branch of the read mux
  // alias redirect
  always_comb
  begin
    sel_reg = avs_address_in[4:2];
    if (!ext_on && sel_reg == DBU_OFF_ALIAS4[4:2])
      sel_reg = DBU_OFF_STATUS[4:2];
    else if (!ext_on && sel_reg == DBU_OFF_ALIAS5[4:2])
      sel_reg = DBU_OFF_CONTROL[4:2];
  end

  // per-breakpoint match and arming
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++)
    begin : g_bp
      logic [1:0] ty;
      logic [1:0] ln;
      logic       kind_ok;
      assign ty = ctl_r[DBU_CTL_TYPE0 + 4*g +: 2];
      assign ln = ctl_r[DBU_CTL_TYPE0 + 4*g + 2 +: 2];
      assign kind_ok = kind_hit(ty, cyc_kind_in);
      assign match_w[g] = cyc_valid_in && kind_ok &&
                          in_range(addr_r[g], ln, cyc_addr_in,
                                   cyc_size_in);
      // global enable arms regardless of local
      assign armed_w[g] = ctl_r[2*g] | ctl_r[2*g+1];
    end
  endgenerate

  // event decode; exact bits deliberately unused
  // every event is taken in the cycle its pulse stands; the pipeline
  // holds nothing for us, so a missed pulse is a lost exception
  // exact bits inert
  assign bp_fault = |(match_w & armed_w) &&
                    cyc_kind_in == DBU_CYC_FETCH;
  assign bp_trap  = |(match_w & armed_w) &&
                    cyc_kind_in != DBU_CYC_FETCH;
  assign step_ev  = instr_done_in && flags_word_in[DBU_FLAGS_TRAP];
  assign task_ev  = task_switch_in && task_trap_bit_in;
  assign guard_ev = dreg_decode_in && ctl_r[DBU_CTL_GUARD];
  assign sw_ev    = instr_done_in && instr_opcode_in == DBU_OP_BKPT;
  assign any_dbg  = bp_fault | bp_trap | step_ev | task_ev | guard_ev;

  // breakpoint address registers
  // plain storage; any value is legal, alignment is left to matching
  // four address registers
  always_ff @(posedge clock_in)
  begin
    for (int i = 0; i < NUM_BP; i++)
    begin
      if (!rst_b_in)
        addr_r[i] <= 32'h0000_0000;
      else if (wr_w && sel_reg == 3'(i))
        addr_r[i] <= be_merge(addr_r[i], avs_writedata_in,
                              avs_byteenable_in);
    end
  end

  // control register; hardware clears win over software writes
  // a write racing a task switch would otherwise re-arm local
  // enables that belong to the task being left
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      ctl_r <= DBU_CTL_RESET;
    else
    begin
      logic [31:0] c;
      c = ctl_r;
      if (wr_w && sel_reg == DBU_OFF_CONTROL[4:2])
        c = (be_merge(ctl_r, avs_writedata_in, avs_byteenable_in)
             & DBU_CTL_WMASK) | DBU_CTL_FIXED1;
      if (task_switch_in)
        c = c & ~32'h0000_0055;
      if (any_dbg)
        c[DBU_CTL_GUARD] = 1'b0;
      ctl_r <= c;
    end
  end

  // status register; sticky, set wins over software write
  // losing a cause to a same-cycle clear would leave the handler
  // with an exception and no recorded reason for it
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      st_r <= DBU_ST_RESET;
    else
    begin
      logic [31:0] s;
      s = st_r;
      if (wr_w && sel_reg == DBU_OFF_STATUS[4:2])
        s = be_merge(st_r, avs_writedata_in, avs_byteenable_in)
            | DBU_ST_FIXED1;
      // hit flags set for every matching condition in a cycle with a debug cause
      s[NUM_BP-1:0] = s[NUM_BP-1:0] | (any_dbg ? match_w : '0);
      if (guard_ev)
        s[DBU_ST_ACCESS] = 1'b1;
      if (step_ev)
        s[DBU_ST_STEP] = 1'b1;
      if (task_ev)
        s[DBU_ST_TASK] = 1'b1;
      st_r <= s;
    end
  end

  // avalon slave: one wait cycle, then answer
  // wait drops for exactly one cycle per request, then rises again
  // while the master releases, so back to back requests stay apart
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      wait_r <= 1'b1;
    else if ((avs_read_in | avs_write_in) && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  // read data mux; unmapped words read zero
  // loaded in the wait cycle and held until the next read
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      rdata_r <= 32'h0000_0000;
    else if (acc_w && avs_read_in)
    begin
      if (sel_reg < 3'(NUM_BP))
        rdata_r <= addr_r[sel_reg[1:0]];
      else if (sel_reg == DBU_OFF_STATUS[4:2])
        rdata_r <= st_r;
      else if (sel_reg == DBU_OFF_CONTROL[4:2])
        rdata_r <= ctl_r;
      else
        rdata_r <= 32'h0000_0000;
    end
  end

  // undefined opcode report for alias moves with extensions on
  // undefined opcode on five/four with extensions
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      undef_r <= 1'b0;
    else
      undef_r <= dreg_decode_in && ext_on &&
                 (dreg_num_in == 3'h4 || dreg_num_in == 3'h5) &&
                 !guard_ev;
  end

  // fault pulse; the handler runs before the instruction
  // exec breakpoints and guard are faults
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      fault_r <= 1'b0;
    else
      fault_r <= bp_fault | guard_ev;
  end

  // trap pulse; a same-cycle fault wins, a step, task or breakpoint hit cause is still
  // recorded in status for the handler to find later; an opcode CCh trap is lost
  // data, io, step and task are traps
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      trap_r <= 1'b0;
    else
      trap_r <= !(bp_fault | guard_ev) &&
                (bp_trap | step_ev | task_ev | sw_ev);
  end

  // vector number, shown only while a report stands
  // debug causes outrank the breakpoint opcode in one cycle
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      vec_r <= 8'h00;
    else if (bp_fault | guard_ev | bp_trap | step_ev | task_ev)
      vec_r <= DBU_VEC_DEBUG;
    else if (sw_ev)
      vec_r <= DBU_VEC_BKPT;
    else
      vec_r <= 8'h00;
  end

  // outputs straight from their flip-flops

  assign avs_readdata_out    = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign fault_out           = fault_r;
  assign trap_out            = trap_r;
  assign vector_out          = vec_r;
  assign undef_op_out        = undef_r;

endmodule // dbu_unit
`default_nettype wire

// *** test/dbu_unit_properties.sv ***
// dbu_unit_check: port-level assertions on the debug unit
// assumes it is bound to dbu_unit and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module dbu_unit_check
  import dbu_pkg::*;
#(
  parameter int NUM_BP = 4
)(
  // clock, reset and register bus
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // processor state and events
  input wire logic [31:0] control_reg_four_in,
  input wire logic [31:0] flags_word_in,
  input wire logic        cyc_valid_in,
  input wire logic        instr_done_in,
  input wire logic [7:0]  instr_opcode_in,
  input wire logic        dreg_decode_in,
  input wire logic [2:0]  dreg_num_in,
  input wire logic        task_switch_in,
  input wire logic        task_trap_bit_in,
  // exception reports
  input wire logic        fault_out,
  input wire logic        trap_out,
  input wire logic [7:0]  vector_out,
  input wire logic        undef_op_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // no cycle or register event, so no fault can mask a trap
  wire logic quiet = !cyc_valid_in && !dreg_decode_in;
  // bus request first seen, then a one-cycle answer
  sequence bus_req_s;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  bus_ans_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not one cycle");
  step_trap_a: assert property (
    quiet && instr_done_in && flags_word_in[DBU_FLAGS_TRAP]
    |=> trap_out && vector_out == DBU_VEC_DEBUG)
    else $error("single step trap missing");
  bkpt_trap_a: assert property (
    quiet && instr_done_in && instr_opcode_in == DBU_OP_BKPT &&
    !flags_word_in[DBU_FLAGS_TRAP] && !task_switch_in
    |=> trap_out && vector_out == DBU_VEC_BKPT)
    else $error("breakpoint opcode trap missing");
  task_trap_a: assert property (
    quiet && task_switch_in && task_trap_bit_in && !instr_done_in
    |=> trap_out && vector_out == DBU_VEC_DEBUG)
    else $error("task switch trap missing");
  vec_idle_a: assert property (
    !fault_out && !trap_out |-> vector_out == 8'h00)
    else $error("vector shown without exception");
  one_kind_a: assert property (fault_out |-> !trap_out)
    else $error("fault and trap together");
  undef_cause_a: assert property (
    undef_op_out |-> $past(dreg_decode_in && dreg_num_in[2:1] == 2'h2
    && control_reg_four_in[DBU_CR4_EXT]))
    else $error("undefined opcode without cause");
  alias_quiet_a: assert property (
    dreg_decode_in && !control_reg_four_in[DBU_CR4_EXT] |=> !undef_op_out)
    else $error("undefined opcode with extensions off");
  alias_zero_a: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in[4:3] == 2'h2
    && control_reg_four_in[DBU_CR4_EXT] |-> avs_readdata_out == 32'h0)
    else $error("alias word not zero with extensions on");
endmodule // dbu_unit_check
bind dbu_unit dbu_unit_check #(.NUM_BP(NUM_BP)) i_dbu_unit_check (
  .clock_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .control_reg_four_in,
  .flags_word_in, .cyc_valid_in, .instr_done_in, .instr_opcode_in,
  .dreg_decode_in, .dreg_num_in, .task_switch_in, .task_trap_bit_in,
  .fault_out, .trap_out, .vector_out, .undef_op_out);
`default_nettype wire

// *** test/dbu_pipe_model.sv ***
// dbu_pipe_model: stand-in for the core pipeline and cycle generator
// assumes one event per call, raised just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module dbu_pipe_model
(
  // core clock
  input  wire logic        clock_in,
  // event lines towards the debug unit
  output var  logic        cyc_valid_out = 1'b0,
  output var  logic [1:0]  cyc_kind_out = 2'h0,
  output var  logic [31:0] cyc_addr_out = 32'h0,
  output var  logic [2:0]  cyc_size_out = 3'h1,
  output var  logic        instr_done_out = 1'b0,
  output var  logic [7:0]  instr_opcode_out = 8'h00,
  output var  logic        dreg_decode_out = 1'b0,
  output var  logic [2:0]  dreg_num_out = 3'h0,
  output var  logic        task_switch_out = 1'b0,
  output var  logic        task_trap_bit_out = 1'b0
);
  // released lines turn inverted so a stale value never matches
  task automatic cyc(input logic [1:0] k, input logic [31:0] a,
                     input logic [2:0] sz);
    @(posedge clock_in);
    cyc_valid_out <= 1'b1;
    {cyc_kind_out, cyc_addr_out, cyc_size_out} <= {k, a, sz};
    @(posedge clock_in);
    cyc_valid_out <= 1'b0;
    {cyc_kind_out, cyc_addr_out, cyc_size_out} <= ~{k, a, sz};
  endtask
  // one completed instruction
  task automatic instr(input logic [7:0] op);
    @(posedge clock_in);
    {instr_done_out, instr_opcode_out} <= {1'b1, op};
    @(posedge clock_in);
    {instr_done_out, instr_opcode_out} <= {1'b0, ~op};
  endtask
  // debug register move decoded
  task automatic dreg(input logic [2:0] n);
    @(posedge clock_in);
    {dreg_decode_out, dreg_num_out} <= {1'b1, n};
    @(posedge clock_in);
    {dreg_decode_out, dreg_num_out} <= {1'b0, ~n};
  endtask
  // task switch, with the new task's trap bit
  task automatic tsw(input logic b);
    @(posedge clock_in);
    {task_switch_out, task_trap_bit_out} <= {1'b1, b};
    @(posedge clock_in);
    {task_switch_out, task_trap_bit_out} <= {1'b0, ~b};
  endtask
endmodule // dbu_pipe_model
`default_nettype wire

// *** test/tb_top.sv ***
// tb_top: register and event tests for the debug breakpoint unit
// assumes the pipeline model drives all event inputs
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dbu_pkg::*;
;
  logic clock_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0;
  logic avs_write_in = 1'b0, avs_waitrequest_out;
  logic [4:0] avs_address_in = 5'h00;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [31:0] control_reg_four_in = 32'h0, flags_word_in = 32'h0;
  logic cyc_valid_in, instr_done_in, dreg_decode_in, task_switch_in;
  logic task_trap_bit_in, fault_out, trap_out, undef_op_out;
  logic [1:0] cyc_kind_in;
  logic [2:0] cyc_size_in, dreg_num_in;
  logic [31:0] cyc_addr_in;
  logic [7:0] instr_opcode_in, vector_out;
  logic [1:0] kinds [4] = '{DBU_CYC_FETCH, DBU_CYC_WRITE, DBU_CYC_IO,
                            DBU_CYC_READ};
  int num_errors = 0, checks_done = 0, cycles = 0;
  always #10 clock_in = ~clock_in;
  dbu_unit i_dbu_unit (.clock_in, .rst_b_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .control_reg_four_in, .flags_word_in, .cyc_valid_in, .cyc_kind_in,
    .cyc_addr_in, .cyc_size_in, .instr_done_in, .instr_opcode_in,
    .dreg_decode_in, .dreg_num_in, .task_switch_in, .task_trap_bit_in,
    .fault_out, .trap_out, .vector_out, .undef_op_out);
  dbu_pipe_model i_dbu_pipe_model (.clock_in,
    .cyc_valid_out(cyc_valid_in), .cyc_kind_out(cyc_kind_in),
    .cyc_addr_out(cyc_addr_in), .cyc_size_out(cyc_size_in),
    .instr_done_out(instr_done_in), .instr_opcode_out(instr_opcode_in),
    .dreg_decode_out(dreg_decode_in), .dreg_num_out(dreg_num_in),
    .task_switch_out(task_switch_in), .task_trap_bit_out(task_trap_bit_in));
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string w, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_in);
    {avs_address_in, avs_writedata_in} <= {a, d};
    {avs_read_in, avs_write_in} <= {!w, w};
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
    q = avs_readdata_out;
    {avs_read_in, avs_write_in} <= 2'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp("register", e, q);
  endtask
  // reports land one edge after the pulse was taken
  task automatic ev(input logic [10:0] e);
    @(posedge clock_in);
    cmp("event", {21'h0, e}, {21'h0, fault_out, trap_out, undef_op_out,
        vector_out});
  endtask
  // hang guard; the run needs well under a thousand cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(DBU_OFF_CONTROL, DBU_CTL_RESET);
    rd(DBU_OFF_STATUS, DBU_ST_RESET);
    for (int i = 0; i < 4; i++) wr(5'(4 * i), 32'h8001_0001 << i);
    for (int i = 0; i < 4; i++) rd(5'(4 * i), 32'h8001_0001 << i);
    avs_byteenable_in <= 4'h1;
    wr(DBU_OFF_ADDR2, 32'hFFFF_FFFF);
    avs_byteenable_in <= 4'hF;
    rd(DBU_OFF_ADDR2, 32'h0004_00FF);
    wr(DBU_OFF_CONTROL, 32'h0000_0300);
    rd(DBU_OFF_CONTROL, 32'h0000_0700);
    wr(DBU_OFF_ALIAS5, 32'h0000_0100);
    rd(DBU_OFF_CONTROL, 32'h0000_0500);
    rd(DBU_OFF_ALIAS4, DBU_ST_RESET);
    i_dbu_pipe_model.dreg(3'h5);
    ev(11'h000);
    control_reg_four_in <= 32'h0000_0008;
    rd(DBU_OFF_ALIAS5, 32'h0);
    i_dbu_pipe_model.dreg(3'h4);
    ev(11'h100);
    flags_word_in <= 32'h0000_0100;
    i_dbu_pipe_model.instr(8'h90);
    ev(11'h201);
    flags_word_in <= 32'h0;
    rd(DBU_OFF_STATUS, 32'hFFFF_4FF0);
    wr(DBU_OFF_CONTROL, 32'h0000_00FF);
    i_dbu_pipe_model.tsw(1'b1);
    ev(11'h201);
    rd(DBU_OFF_CONTROL, 32'h0000_04AA);
    rd(DBU_OFF_STATUS, 32'hFFFF_CFF0);
    i_dbu_pipe_model.tsw(1'b0);
    ev(11'h000);
    wr(DBU_OFF_STATUS, 32'h0);
    rd(DBU_OFF_STATUS, DBU_ST_RESET);
    i_dbu_pipe_model.instr(DBU_OP_BKPT);
    ev(11'h203);
    // restored first byte runs without a new trap
    i_dbu_pipe_model.instr(8'h90);
    ev(11'h000);
    wr(DBU_OFF_CONTROL, 32'h0000_2000);
    i_dbu_pipe_model.dreg(3'h7);
    ev(11'h401);
    rd(DBU_OFF_CONTROL, DBU_CTL_RESET);
    rd(DBU_OFF_STATUS, 32'hFFFF_2FF0);
    wr(DBU_OFF_ADDR0, 32'h0000_1000);
    wr(DBU_OFF_ADDR1, 32'h0000_1000);
    for (int t = 0; t < 4; t++)
    begin
      wr(DBU_OFF_STATUS, 32'h0);
      // exec keeps size 00, others four bytes; io matches whatever the extensions bit, which stays on from earlier
      wr(DBU_OFF_CONTROL, 32'h2 | (t == 0 ? 32'h0 : 32'hC_0000) |
         (32'(t) << 16));
      i_dbu_pipe_model.cyc(kinds[t], 32'h1000, t == 0 ? 3'h1 : 3'h4);
      ev(t == 0 ? 11'h401 : 11'h201);
      rd(DBU_OFF_STATUS, t == 0 ? 32'hFFFF_0FF3 : 32'hFFFF_0FF1);
      i_dbu_pipe_model.cyc(t == 0 ? kinds[3] : kinds[0], 32'h1000, 3'h1);
      ev(11'h000);
    end
    wr(DBU_OFF_CONTROL, 32'h0);
    i_dbu_pipe_model.cyc(kinds[0], 32'h1000, 3'h1);
    ev(11'h000);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
